// ===== logic/fifo_reset_ctrl.sv
// reset, partial reset and rewind control for a dual-clock fifo
// assumes port clocks run well below half of clk_sys so each edge is seen
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none

//
// Overview of operation
// - full reset needs four write-clock and four read-clock rising edges
// - full-reset inputs may change at any time; they are synchronised
// - full reset clears pointers, ready and empty low, almost-empty low, almost-full high
// - primary reset forces mail1 flag high; secondary forces mail2 flag high
// - input ready rises two write-clock edges after full reset ends
// - endian select captured on primary reset rising edge
// - three offset selects captured on primary reset rising edge
// - partial reset needs four write-clock and four read-clock edges
// - partial-clear input may change at any time; it is synchronised
// - partial reset clears pointers and forces the same flag levels
// - partial reset forces both mail flags high
// - input ready rises two write-clock edges after partial reset ends
// - partial reset keeps offsets, programming method and timing mode
// - with rewind mode high the pulse rewinds only the read pointer
// - endian select high means big-endian, low means little-endian
// - full reset clears the read-port output register
module fifo_reset_ctrl
  import fifo_reset_pkg::*;
#(
  parameter int EDGES = MIN_RESET_EDGES
) (
  // system
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  // register port
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_write,
  input  wire logic         reg_read,
  output logic [31:0]       reg_rdata,
  output logic              irq,
  // fifo pins
  input  wire logic         primary_reset_n,
  input  wire logic         secondary_reset_n,
  input  wire logic         partial_clear_n,
  input  wire logic         rewind_mode_select,
  input  wire logic         write_port_clock,
  input  wire logic         read_port_clock,
  input  wire logic         endian_timing_select,
  input  wire logic         offset_select_0,
  input  wire logic         offset_select_1,
  input  wire logic         offset_select_2,
  // to the fifo core
  output fifo_flags_t       flags,
  output fifo_config_t      config_out,
  output logic              write_ptr_clear,
  output logic              read_ptr_clear,
  output logic              output_reg_clear
);

  logic [SYNC_W-1:0]     sync1_reg;
  logic [SYNC_W-1:0]     sync2_reg;
  logic [SYNC_W-1:0]     sync3_reg;
  logic                  prim_low;
  logic                  sec_low;
  logic                  part_low;
  logic                  full_low;
  logic                  any_low;
  logic                  any_low_reg;
  logic                  wclk_rise;
  logic                  rclk_rise;
  logic                  prim_rise;
  logic                  release_evt;
  logic                  start_evt;
  logic [EDGE_CNT_W-1:0] wcnt_reg;
  logic [EDGE_CNT_W-1:0] rcnt_reg;
  logic                  qualified;
  logic                  saw_full_reg;
  logic                  saw_partial_reg;
  logic                  rewind_reg;
  logic                  fwft_pending_reg;
  logic                  ready_reg;
  ctl_state_t            state_reg;
  logic [EV_WIDTH-1:0]   status_reg;
  logic [EV_WIDTH-1:0]   mask_reg;
  logic [0:0]            ctrl_reg;
  logic [EV_WIDTH-1:0]   events;
  logic                  pins_hold;
  logic                  rewind_now;
  logic                  good_release;
  logic                  mail1_force;
  logic                  mail2_force;

  // port clocks are sampled as data: each high and low must span two system cycles
  // synchronise resets and port clocks
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
      sync3_reg <= SYNC_RESET;
    end else begin
      sync1_reg <= {read_port_clock, write_port_clock, partial_clear_n,
                    secondary_reset_n, primary_reset_n};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign prim_low  = !sync2_reg[LN_PRIMARY];
  assign sec_low   = !sync2_reg[LN_SECONDARY];
  assign part_low  = !sync2_reg[LN_PARTIAL];
  assign full_low  = prim_low && sec_low;
  assign any_low   = full_low || part_low;
  assign wclk_rise = sync2_reg[LN_WCLK] && !sync3_reg[LN_WCLK];
  assign rclk_rise = sync2_reg[LN_RCLK] && !sync3_reg[LN_RCLK];
  assign prim_rise = sync2_reg[LN_PRIMARY] && !sync3_reg[LN_PRIMARY];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      any_low_reg <= 1'b0;
    end else begin
      any_low_reg <= any_low;
    end
  end

  assign start_evt   = any_low && !any_low_reg;
  assign release_evt = !any_low && any_low_reg;

  // count port clock edges separately while a reset is low
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wcnt_reg <= '0;
      rcnt_reg <= '0;
    end else if (!any_low) begin
      wcnt_reg <= '0;
      rcnt_reg <= '0;
    end else begin
      if (wclk_rise && wcnt_reg < EDGE_CNT_W'(EDGES)) begin
        wcnt_reg <= wcnt_reg + 1'b1;
      end
      if (rclk_rise && rcnt_reg < EDGE_CNT_W'(EDGES)) begin
        rcnt_reg <= rcnt_reg + 1'b1;
      end
    end
  end

  // both counts must reach the limit; a short pulse raises an event but neither starts input ready nor rewinds
  assign qualified = (wcnt_reg >= EDGE_CNT_W'(EDGES))
                  && (rcnt_reg >= EDGE_CNT_W'(EDGES));

  // remember what kind of reset is in progress
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      saw_full_reg    <= 1'b0;
      saw_partial_reg <= 1'b0;
      rewind_reg      <= 1'b0;
    end else if (start_evt) begin
      saw_full_reg    <= full_low;
      saw_partial_reg <= part_low && !full_low && !rewind_mode_select;
      rewind_reg      <= part_low && !full_low && rewind_mode_select;
    end else if (any_low) begin
      if (full_low) begin
        saw_full_reg <= 1'b1;
        rewind_reg   <= 1'b0;
      end
    end
  end

  // classify a pulse from its first cycle, before rewind_reg has caught up
  assign rewind_now   = start_evt ? (rewind_mode_select && !full_low) : rewind_reg;
  assign good_release = release_evt && qualified;

  // a rewind pulse leaves the write side alone
  assign pins_hold   = full_low || (part_low && !rewind_now);
  assign mail1_force = prim_low || (part_low && !rewind_now);
  assign mail2_force = sec_low || (part_low && !rewind_now);

  // sequencer for input ready after release
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_HOLD;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          if (pins_hold) begin
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (good_release && !rewind_reg) begin
            state_reg <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (pins_hold) begin
            state_reg <= ST_HOLD;
          end else if (wclk_rise) begin
            state_reg <= ST_LAST;
          end
        end
        ST_LAST: begin
          if (pins_hold) begin
            state_reg <= ST_HOLD;
          end else if (wclk_rise) begin
            state_reg <= ST_RUN;
          end
        end
      endcase
    end
  end

  // flags: cleared levels while held, ready once the sequence ends
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= (state_reg == ST_LAST) && wclk_rise && !pins_hold;
      if (state_reg == ST_RUN && !pins_hold) begin
        ready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flags <= FLAGS_CLEARED;
    end else begin
      flags.full_or_input_ready   <= ready_reg && !pins_hold;
      flags.empty_or_output_ready <= 1'b0;
      flags.almost_empty_n        <= 1'b0;
      flags.almost_full_n         <= 1'b1;
      if (mail1_force) begin
        flags.mail1_full_flag_n <= 1'b1;
      end
      if (mail2_force) begin
        flags.mail2_full_flag_n <= 1'b1;
      end
    end
  end

  // pointer and output register clears
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      write_ptr_clear  <= 1'b1;
      output_reg_clear <= 1'b1;
    end else begin
      write_ptr_clear  <= pins_hold;
      output_reg_clear <= pins_hold;
    end
  end

  // read pointer: cleared with the hold, or pulsed once by an enabled rewind
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      read_ptr_clear <= 1'b1;
    end else begin
      read_ptr_clear <= pins_hold || (good_release && rewind_reg
                        && ctrl_reg[CTRL_REWIND_EN]);
    end
  end

  // configuration: latched only by the primary reset, kept by partial reset
  // timing mode follows at the first write-clock edge after release
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      config_out       <= CONFIG_RESET;
      fwft_pending_reg <= 1'b0;
    end else if (prim_rise) begin
      config_out.big_endian    <= endian_timing_select;
      config_out.offset_select <= {offset_select_2, offset_select_1,
                                   offset_select_0};
      fwft_pending_reg         <= 1'b1;
    end else if (fwft_pending_reg && wclk_rise) begin
      config_out.first_word_fall_through <= !endian_timing_select;
      fwft_pending_reg                   <= 1'b0;
    end
  end

  // events
  always_comb begin
    events = '0;
    events[EV_FULL_DONE]    = good_release && saw_full_reg;
    events[EV_PARTIAL_DONE] = good_release && saw_partial_reg
                              && !saw_full_reg;
    events[EV_REWIND_DONE]  = good_release && rewind_reg
                              && ctrl_reg[CTRL_REWIND_EN];
    events[EV_SHORT_PULSE]  = release_evt && !qualified;
  end

  // status: set wins over write-one-to-clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~((reg_write && reg_addr == ADDR_STATUS)
                    ? reg_wdata[EV_WIDTH-1:0] : '0)) | events;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mask_reg <= MASK_RESET;
    end else if (reg_write && reg_addr == ADDR_MASK) begin
      mask_reg <= reg_wdata[EV_WIDTH-1:0];
    end
  end

  // control: rewind enable
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= CTRL_RESET;
    end else if (reg_write && reg_addr == ADDR_CONTROL) begin
      ctrl_reg <= reg_wdata[0:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // read data valid the cycle after the strobe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      unique case (reg_addr)
        ADDR_STATUS:  reg_rdata <= {28'h0000000, status_reg};
        ADDR_MASK:    reg_rdata <= {28'h0000000, mask_reg};
        ADDR_CONTROL: reg_rdata <= {31'h00000000, ctrl_reg};
        ADDR_STATE:   reg_rdata <= {19'h00000, config_out, flags, state_reg};
        default:      reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule // fifo_reset_ctrl

`default_nettype wire

// ===== common/fifo_reset_pkg.sv
// constants and carrier types for the fifo reset and partial-reset controller
// assumes one system clock; port clocks and reset pins arrive as plain inputs
package fifo_reset_pkg;

  // register map (byte addresses)
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_MASK    = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_STATE   = 8'h0C;

  // status and mask bit positions
  localparam int EV_FULL_DONE    = 0;
  localparam int EV_PARTIAL_DONE = 1;
  localparam int EV_REWIND_DONE  = 2;
  localparam int EV_SHORT_PULSE  = 3;
  localparam int EV_WIDTH        = 4;

  // control bits and reset value
  localparam int              CTRL_REWIND_EN = 0;
  localparam logic [0:0]      CTRL_RESET     = 1'h1;
  localparam logic [EV_WIDTH-1:0] MASK_RESET = 4'h0;

  // qualifying rising edges of each port clock while a reset is low
  localparam int MIN_RESET_EDGES = 4;
  // write-clock edges from reset release to input ready
  localparam int READY_DELAY_EDGES = 2;
  localparam int EDGE_CNT_W = 3;

  // synchroniser lanes
  localparam int LN_PRIMARY   = 0;
  localparam int LN_SECONDARY = 1;
  localparam int LN_PARTIAL   = 2;
  localparam int LN_WCLK      = 3;
  localparam int LN_RCLK      = 4;
  localparam int SYNC_W       = 5;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h07;

  typedef enum logic [1:0] {
    ST_RUN    = 2'h0,
    ST_HOLD   = 2'h1,
    ST_SETTLE = 2'h3,
    ST_LAST   = 2'h2
  } ctl_state_t;

  typedef struct packed {
    logic full_or_input_ready;
    logic empty_or_output_ready;
    logic almost_empty_n;
    logic almost_full_n;
    logic mail1_full_flag_n;
    logic mail2_full_flag_n;
  } fifo_flags_t;

  // flags while a reset or partial reset holds the fifo
  localparam fifo_flags_t FLAGS_CLEARED = 6'h07;

  typedef struct packed {
    logic       big_endian;
    logic       first_word_fall_through;
    logic [2:0] offset_select;
  } fifo_config_t;

  localparam fifo_config_t CONFIG_RESET = 5'h00;

endpackage

// ===== verification/fifo_reset_ctrl_asserts.sv
// checker for the fifo reset controller, watching the top ports only
// assumes a single clk_sys domain and bind onto fifo_reset_ctrl
`timescale 1ns/10ps
`default_nettype none
module fifo_reset_ctrl_asserts
  import fifo_reset_pkg::*;
(
  // system and pins
  input wire logic         clk_sys,
  input wire logic         reset_n,
  input wire logic         reg_read,
  input wire logic [31:0]  reg_rdata,
  input wire logic         primary_reset_n,
  input wire logic         secondary_reset_n,
  input wire logic         partial_clear_n,
  input wire logic         rewind_mode_select,
  input wire logic         write_port_clock,
  // outputs
  input wire fifo_flags_t  flags,
  input wire fifo_config_t config_out,
  input wire logic         write_ptr_clear,
  input wire logic         read_ptr_clear,
  input wire logic         output_reg_clear
);
  logic       wclk_q;
  logic [2:0] wedges;
  logic [4:0] since_prim;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // write-clock edges since the clears dropped, and cycles since primary low
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wclk_q <= 1'b0;
      wedges <= 3'h0;
      since_prim <= 5'h00;
    end else begin
      wclk_q <= write_port_clock;
      if (write_ptr_clear) wedges <= 3'h0;
      else if (write_port_clock && !wclk_q && wedges != 3'h7) wedges <= wedges + 3'h1;
      if (!primary_reset_n) since_prim <= 5'h00;
      else if (since_prim != 5'h1F) since_prim <= since_prim + 5'h01;
    end
  end
  property p_hold_flags;
    write_ptr_clear && $past(write_ptr_clear) |-> flags == FLAGS_CLEARED;
  endproperty
  a_hold_flags: assert property (p_hold_flags)
    else $error("flags not at cleared levels during hold");
  property p_ready_rise;
    $rose(flags.full_or_input_ready) |-> !write_ptr_clear && wedges >= 3'h1;
  endproperty
  a_ready_rise: assert property (p_ready_rise)
    else $error("ready rose without write clock edges");
  property p_read_clr;
    write_ptr_clear |-> read_ptr_clear;
  endproperty
  a_read_clr: assert property (p_read_clr)
    else $error("read pointer not cleared with write pointer");
  property p_out_clr;
    output_reg_clear == write_ptr_clear;
  endproperty
  a_out_clr: assert property (p_out_clr)
    else $error("output register clear differs from hold");
  property p_rewind;
    read_ptr_clear && !write_ptr_clear |=> !read_ptr_clear;
  endproperty
  a_rewind: assert property (p_rewind)
    else $error("rewind pulse longer than one cycle");
  property p_prim_hold;
    $fell(primary_reset_n) && !secondary_reset_n |-> ##[1:4]
      (write_ptr_clear && !flags.full_or_input_ready);
  endproperty
  a_prim_hold: assert property (p_prim_hold)
    else $error("full reset not applied");
  property p_mail;
    $fell(primary_reset_n) || $fell(secondary_reset_n) |-> ##[1:4]
      (flags.mail1_full_flag_n && flags.mail2_full_flag_n);
  endproperty
  a_mail: assert property (p_mail)
    else $error("mail flags not forced high");
  property p_partial;
    $fell(partial_clear_n) && !rewind_mode_select |-> ##[1:4] write_ptr_clear;
  endproperty
  a_partial: assert property (p_partial)
    else $error("partial reset not applied");
  property p_rw_keep;
    $fell(partial_clear_n) && rewind_mode_select && !write_ptr_clear
      && primary_reset_n && secondary_reset_n |-> !write_ptr_clear [*8];
  endproperty
  a_rw_keep: assert property (p_rw_keep)
    else $error("rewind cleared the write pointer");
  property p_config;
    !$stable({config_out.big_endian, config_out.offset_select}) |-> since_prim < 5'h08;
  endproperty
  a_config: assert property (p_config)
    else $error("config changed away from primary release");
  property p_rdata;
    !$past(reg_read) |-> reg_rdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data outside read slot");
  c_ready: cover property ($rose(flags.full_or_input_ready));
  c_rewind: cover property (read_ptr_clear && !write_ptr_clear);
  c_partial: cover property ($fell(partial_clear_n) && !rewind_mode_select);
endmodule // fifo_reset_ctrl_asserts
bind fifo_reset_ctrl fifo_reset_ctrl_asserts u_chk (.clk_sys, .reset_n, .reg_read,
  .reg_rdata, .primary_reset_n, .secondary_reset_n, .partial_clear_n, .rewind_mode_select,
  .write_port_clock, .flags, .config_out, .write_ptr_clear, .read_ptr_clear,
  .output_reg_clear);
`default_nettype wire

// ===== verification/port_clock_host.sv
// host model: free-running write and read port clocks
// assumes the bench drives the reset pins
`timescale 1ns/10ps
`default_nettype none
module port_clock_host #(
  parameter int W_HALF = 40,
  parameter int R_HALF = 55
) (
  // port clocks
  output var logic write_port_clock,
  output var logic read_port_clock
);
  // edges keep coming while resets are held
  initial write_port_clock = 1'b0;
  initial read_port_clock = 1'b0;
  always #W_HALF write_port_clock = ~write_port_clock;
  always #R_HALF read_port_clock = ~read_port_clock;
endmodule // port_clock_host
`default_nettype wire

// ===== verification/dual_clock_fifo_reset_control_bench.sv
// self-checking bench for the fifo reset controller
// assumes port_clock_host makes the port clocks
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module dual_clock_fifo_reset_control_bench;
  import fifo_reset_pkg::*;
  logic clk_sys = 0, reset_n = 0, reg_write = 0, reg_read = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic irq, write_ptr_clear, read_ptr_clear, output_reg_clear;
  logic write_port_clock, read_port_clock, endian_timing_select = 1;
  logic primary_reset_n = 1, secondary_reset_n = 1, partial_clear_n = 1;
  logic rewind_mode_select = 0, offset_select_0 = 0, offset_select_1 = 0, offset_select_2 = 0;
  fifo_flags_t flags;
  fifo_config_t config_out;
  int errors = 0, cmp_count = 0, pulses = 0;
  port_clock_host host (.write_port_clock, .read_port_clock);
  fifo_reset_ctrl dut (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .irq, .primary_reset_n, .secondary_reset_n, .partial_clear_n,
    .rewind_mode_select, .write_port_clock, .read_port_clock, .endian_timing_select,
    .offset_select_0, .offset_select_1, .offset_select_2, .flags, .config_out,
    .write_ptr_clear, .read_ptr_clear, .output_reg_clear);
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (read_ptr_clear && !write_ptr_clear) pulses++;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  // m is {rewind mode, primary, secondary, partial}; hold n edges of each port clock
  task automatic pulse(input logic [3:0] m, input int n, input logic e, input logic [2:0] f);
    @(posedge clk_sys);
    rewind_mode_select <= m[3];
    primary_reset_n <= !m[2];
    secondary_reset_n <= !m[1];
    partial_clear_n <= !m[0];
    endian_timing_select <= e;
    {offset_select_2, offset_select_1, offset_select_0} <= f;
    fork
      repeat (n) @(posedge write_port_clock);
      repeat (n) @(posedge read_port_clock);
    join
    @(posedge clk_sys);
    primary_reset_n <= 1'b1;
    secondary_reset_n <= 1'b1;
    partial_clear_n <= 1'b1;
    repeat (12) @(posedge clk_sys);
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_ready();
    int i;
    for (i = 0; i < 300 && flags.full_or_input_ready !== 1'b1; i++) @(posedge clk_sys);
    if (i == 300) begin
      errors++;
      $display("ERROR %0t ready timeout", $time);
      end_of_test();
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(ADDR_MASK, 32'h0);
    rd(ADDR_CONTROL, 32'h1);
    rd(ADDR_STATE, 32'h1D);
    rd(8'h10, 32'h0);
    wr(ADDR_MASK, 32'hF);
    pulse(4'b0110, 6, 1'b1, 3'b101);
    wait_ready();
    `CHK(config_out, 5'h15)
    `CHK(flags, 6'h27)
    rd(ADDR_STATUS, 32'h1);
    `CHK(irq, 1'b1)
    wr(ADDR_STATUS, 32'h1);
    rd(ADDR_STATUS, 32'h0);
    `CHK(irq, 1'b0)
    rd(ADDR_STATE, 32'h159C);
    pulse(4'b0001, 2, 1'b0, 3'b000);
    repeat (40) @(posedge clk_sys);
    `CHK(flags.full_or_input_ready, 1'b0)
    rd(ADDR_STATUS, 32'h8);
    wr(ADDR_STATUS, 32'h8);
    pulse(4'b0001, 6, 1'b0, 3'b010);
    wait_ready();
    `CHK(config_out, 5'h15)
    rd(ADDR_STATUS, 32'h2);
    wr(ADDR_STATUS, 32'h2);
    pulse(4'b1001, 6, 1'b0, 3'b010);
    rd(ADDR_STATUS, 32'h4);
    `CHK(pulses, 1)
    `CHK(flags.full_or_input_ready, 1'b1)
    wr(ADDR_CONTROL, 32'h0);
    pulse(4'b1001, 6, 1'b0, 3'b010);
    `CHK(pulses, 1)
    pulse(4'b0110, 6, 1'b0, 3'b010);
    wait_ready();
    `CHK(config_out, 5'h0A)
    end_of_test();
  end
endmodule // dual_clock_fifo_reset_control_bench
`default_nettype wire
